// *** rtl/obc_pkg.sv ***
// shared constants and types for the option byte configuration decoder
`default_nettype none
package obc_pkg;
  // ----------------------------------------------------------------
  // option byte layout and blank content
  // ----------------------------------------------------------------
  localparam logic [7:0] OPT0_BLANK    = 8'hE7;
  localparam logic [7:0] OPT1_BLANK    = 8'hEF;
  localparam logic [7:0] OPT_ERASED    = 8'hFF;
  // byte zero fields
  localparam int B0_HALT_WDG_RST       = 7;
  localparam int B0_WDG_TYPE           = 6;
  localparam int B0_RSVD_HI            = 5;
  localparam int B0_VD_HI              = 4;
  localparam int B0_VD_LO              = 3;
  localparam int B0_RSVD_LO            = 2;
  localparam int B0_PKG_LOW            = 1;
  localparam int B0_READOUT            = 0;
  // byte one fields
  localparam int B1_PKG_HIGH           = 7;
  localparam int B1_RST_CYC            = 6;
  localparam int B1_CLK_HI             = 5;
  localparam int B1_CLK_LO             = 4;
  localparam int B1_RANGE_HI           = 3;
  localparam int B1_RANGE_LO           = 1;
  localparam int B1_DBL_OFF            = 0;
  // ----------------------------------------------------------------
  // timing counts in cpu cycles
  // ----------------------------------------------------------------
  localparam int CNT_W                 = 13;
  localparam logic [CNT_W-1:0] RST_CYC_LONG  = 13'h1000;
  localparam logic [CNT_W-1:0] RST_CYC_SHORT = 13'h0100;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VD_HIGHEST = 2'h0,
    VD_MEDIUM  = 2'h1,
    VD_LOWEST  = 2'h2,
    VD_OFF     = 2'h3
  } obc_vd_t;
  typedef enum logic [1:0] {
    CLK_RESONATOR = 2'h0,
    CLK_RESERVED  = 2'h1,
    CLK_INT_RC    = 2'h2,
    CLK_EXTERNAL  = 2'h3
  } obc_clk_t;
  localparam logic [2:0] RANGE_2_4MHZ  = 3'h1;
  localparam logic [1:0] PKG_64PIN     = 2'h2;
  localparam logic [1:0] PKG_44PIN     = 2'h0;
  // warning flag positions
  localparam int WARN_RSVD_BITS        = 0;
  localparam int WARN_PROT_LVD         = 1;
  localparam int WARN_DOUBLER          = 2;
  localparam int WARN_CLK_RSVD         = 3;
  localparam int WARN_W                = 4;
endpackage : obc_pkg
`default_nettype wire

// *** rtl/obc_opt_store.sv ***
// non-volatile option byte cells with write and erase
`default_nettype none
module obc_opt_store (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       wr_in,
  input  wire logic       sel_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       erase_in,
  output logic      [7:0] byte0_out,
  output logic      [7:0] byte1_out
);
  import obc_pkg::*;

  logic [7:0] b0_r;
  logic [7:0] b0_nxt;
  logic [7:0] b1_r;
  logic [7:0] b1_nxt;

  // erase has priority over a write in the same cycle
  always_comb begin
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    if (erase_in) begin
      b0_nxt = OPT_ERASED;
      b1_nxt = OPT_ERASED;
    end else if (wr_in && !sel_in) begin
      b0_nxt = wdata_in;
    end else if (wr_in && sel_in) begin
      b1_nxt = wdata_in;
    end
  end

  // blank shipped content selects the internal rc source
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      b0_r <= OPT0_BLANK;
      b1_r <= OPT1_BLANK;
    end else begin
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
    end
  end

  assign byte0_out = b0_r;
  assign byte1_out = b1_r;
endmodule // obc_opt_store
`default_nettype wire

// *** rtl/obc_delay_cnt.sv ***
// down counter for reset and halt exit delays
`default_nettype none
module obc_delay_cnt #(
  parameter int W = 13
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_in) begin
      cnt_nxt = count_in;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // last cycle of the loaded span
  assign done_out = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !load_in;
endmodule // obc_delay_cnt
`default_nettype wire

// *** rtl/obc_config_top.sv ***
// option byte configuration decoder, reset sequencer and programming access
`default_nettype none
module obc_config_top
  import obc_pkg::*;
#(
  parameter bit                        FACTORY_CODED = 1'b0,
  parameter int                        N_PORTS       = 6,
  parameter logic [N_PORTS*8-1:0]      UNBONDED_64   = 48'h0000_0000_0000,
  parameter logic [N_PORTS*8-1:0]      UNBONDED_44   = 48'hFF00_0000_F000,
  parameter logic [obc_pkg::CNT_W-1:0] LONG_CYCLES   = obc_pkg::RST_CYC_LONG,
  parameter logic [obc_pkg::CNT_W-1:0] SHORT_CYCLES  = obc_pkg::RST_CYC_SHORT
) (
  input  wire logic                   CLK_SYS_IN,
  input  wire logic                   ARST_N_IN,
  input  wire logic                   PROG_MODE_IN,
  input  wire logic                   PROG_SEL_IN,
  input  wire logic                   PROG_WR_IN,
  input  wire logic                   PROG_RD_IN,
  input  wire logic                   PROG_ERASE_IN,
  input  wire logic [7:0]             PROG_WDATA_IN,
  input  wire logic                   USER_ERASE_DONE_IN,
  input  wire logic                   HALT_REQ_IN,
  input  wire logic                   HALT_WAKE_IN,
  input  wire logic                   WATCHDOG_TYPE_SELECT_ENABLE_IN,
  output logic      [7:0]             PROG_RDATA_OUT,
  output logic                        PROG_RVALID_OUT,
  output logic                        PROG_BUSY_OUT,
  output logic                        USER_ERASE_REQ_OUT,
  output logic                        CPU_RUN_OUT,
  output logic                        SYS_RESET_OUT,
  output logic                        HALT_ACTIVE_OUT,
  output logic                        WDG_ENABLE_OUT,
  output logic                        LVD_ENABLE_OUT,
  output logic                        AVD_ENABLE_OUT,
  output logic      [1:0]             VD_LEVEL_OUT,
  output logic      [1:0]             PKG_SEL_OUT,
  output logic      [N_PORTS*8-1:0]   PAD_PULLUP_FORCE_OUT,
  output logic                        READOUT_BLOCK_OUT,
  output logic                        FLASH_WR_BLOCK_OUT,
  output logic      [1:0]             CLK_SRC_OUT,
  output logic      [2:0]             FREQ_RANGE_OUT,
  output logic                        RES_CURRENT_EN_OUT,
  output logic                        PLL_EN_OUT,
  output logic      [WARN_W-1:0]      CFG_WARN_OUT
);
  import obc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic PROT_LEVEL = FACTORY_CODED ? 1'b1 : 1'b0;
  localparam int   SYNC_W     = 13;

  function automatic logic prot_on(input logic [7:0] b0);
    prot_on = (b0[B0_READOUT] == PROT_LEVEL);
  endfunction

  function automatic logic [CNT_W-1:0] span(input logic [7:0] b1);
    span = b1[B1_RST_CYC] ? SHORT_CYCLES : LONG_CYCLES;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [2:0]        s3_r;
  logic              prog_mode;
  logic              prog_sel;
  logic [7:0]        prog_wdata;
  logic              wr_stb;
  logic              rd_stb;
  logic              er_stb;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {PROG_MODE_IN, PROG_SEL_IN, PROG_WR_IN, PROG_RD_IN, PROG_ERASE_IN, PROG_WDATA_IN};
      s2_r <= s1_r;
      s3_r <= s2_r[10:8];
    end
  end

  assign prog_mode  = s2_r[12];
  assign prog_sel   = s2_r[11];
  assign prog_wdata = s2_r[7:0];
  // tool strobes are levels; act on their rising edge
  assign wr_stb     = s2_r[10] && !s3_r[2];
  assign rd_stb     = s2_r[9] && !s3_r[1];
  assign er_stb     = s2_r[8] && !s3_r[0];

  // ----------------------------------------------------------------
  // option byte cells and programming access
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_USER = 2'h1,
    E_OPT  = 2'h2
  } obc_erase_t;

  obc_erase_t er_st_r;
  obc_erase_t er_st_nxt;
  logic [7:0] store_b0;
  logic [7:0] store_b1;
  logic       st_wr;
  logic       st_erase;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  always_comb begin
    er_st_nxt  = er_st_r;
    st_wr      = 1'b0;
    st_erase   = 1'b0;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    case (er_st_r)
      E_IDLE: begin
        if (prog_mode) begin
          if (er_stb) begin
            er_st_nxt = prot_on(store_b0) ? E_USER : E_OPT;
          end else if (wr_stb) begin
            st_wr = 1'b1;
          end else if (rd_stb) begin
            rdata_nxt  = prog_sel ? store_b1 : store_b0;
            rvalid_nxt = 1'b1;
          end
        end
      end
      E_USER: begin
        if (USER_ERASE_DONE_IN) begin
          er_st_nxt = E_OPT;
        end
      end
      E_OPT: begin
        st_erase  = 1'b1;
        er_st_nxt = E_IDLE;
      end
      default: begin
        er_st_nxt = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      er_st_r  <= E_IDLE;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      er_st_r  <= er_st_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  obc_opt_store u_store (
    .clk_in    (CLK_SYS_IN),
    .arst_n_in (ARST_N_IN),
    .wr_in     (st_wr),
    .sel_in    (prog_sel),
    .wdata_in  (prog_wdata),
    .erase_in  (st_erase),
    .byte0_out (store_b0),
    .byte1_out (store_b1)
  );

  assign PROG_RDATA_OUT     = rdata_r;
  assign PROG_RVALID_OUT    = rvalid_r;
  assign PROG_BUSY_OUT      = (er_st_r != E_IDLE);
  assign USER_ERASE_REQ_OUT = (er_st_r == E_USER);

  // ----------------------------------------------------------------
  // reset and halt sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    Q_LOAD = 3'h0,
    Q_RST  = 3'h1,
    Q_RUN  = 3'h2,
    Q_HALT = 3'h3,
    Q_EXIT = 3'h4
  } obc_seq_t;

  obc_seq_t   seq_r;
  obc_seq_t   seq_nxt;
  logic [7:0] act0_r;
  logic [7:0] act0_nxt;
  logic [7:0] act1_r;
  logic [7:0] act1_nxt;
  logic       cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic       cnt_done;
  logic       wdg_on;

  assign wdg_on = !act0_r[B0_WDG_TYPE] || WATCHDOG_TYPE_SELECT_ENABLE_IN;

  always_comb begin
    seq_nxt  = seq_r;
    act0_nxt = act0_r;
    act1_nxt = act1_r;
    cnt_load = 1'b0;
    cnt_val  = span(act1_r);
    case (seq_r)
      Q_LOAD: begin
        act0_nxt = store_b0;
        act1_nxt = store_b1;
        cnt_val  = span(store_b1);
        cnt_load = 1'b1;
        seq_nxt  = Q_RST;
      end
      Q_RST: begin
        if (cnt_done) begin
          seq_nxt = Q_RUN;
        end
      end
      Q_RUN: begin
        if (HALT_REQ_IN) begin
          if (act0_r[B0_HALT_WDG_RST] && wdg_on) begin
            seq_nxt = Q_LOAD;
          end else begin
            seq_nxt = Q_HALT;
          end
        end
      end
      Q_HALT: begin
        if (HALT_WAKE_IN) begin
          cnt_load = 1'b1;
          seq_nxt  = Q_EXIT;
        end
      end
      Q_EXIT: begin
        if (cnt_done) begin
          seq_nxt = Q_RUN;
        end
      end
      default: begin
        seq_nxt = Q_LOAD;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      seq_r  <= Q_LOAD;
      act0_r <= OPT0_BLANK;
      act1_r <= OPT1_BLANK;
    end else begin
      seq_r  <= seq_nxt;
      act0_r <= act0_nxt;
      act1_r <= act1_nxt;
    end
  end

  obc_delay_cnt #(
    .W (CNT_W)
  ) u_delay (
    .clk_in    (CLK_SYS_IN),
    .arst_n_in (ARST_N_IN),
    .load_in   (cnt_load),
    .count_in  (cnt_val),
    .done_out  (cnt_done)
  );

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [1:0]           vd_f;
  logic [1:0]           pkg_f;
  logic [1:0]           clk_f;
  logic [2:0]           rng_f;
  logic                 prot_f;
  logic                 dbl_f;
  logic [N_PORTS*8-1:0] pad_nxt;
  logic [WARN_W-1:0]    warn_nxt;
  logic [N_PORTS*8-1:0] pad_r;
  logic [WARN_W-1:0]    warn_r;
  logic [15:0]          dec_nxt;
  logic [15:0]          dec_r;

  assign vd_f   = act0_r[B0_VD_HI:B0_VD_LO];
  assign pkg_f  = {act1_r[B1_PKG_HIGH], act0_r[B0_PKG_LOW]};
  assign clk_f  = act1_r[B1_CLK_HI:B1_CLK_LO];
  assign rng_f  = act1_r[B1_RANGE_HI:B1_RANGE_LO];
  assign prot_f = prot_on(act0_r);
  assign dbl_f  = !act1_r[B1_DBL_OFF];

  always_comb begin
    pad_nxt = (pkg_f == PKG_44PIN) ? UNBONDED_44 : UNBONDED_64;
    // far side combinations flagged, not corrected
    warn_nxt = '0;
    warn_nxt[WARN_RSVD_BITS] = !(act0_r[B0_RSVD_HI] && act0_r[B0_RSVD_LO]);
    warn_nxt[WARN_PROT_LVD]  = prot_f && (vd_f != VD_OFF);
    warn_nxt[WARN_DOUBLER]   = dbl_f && ((rng_f != RANGE_2_4MHZ) || (clk_f == CLK_INT_RC));
    warn_nxt[WARN_CLK_RSVD]  = (clk_f == CLK_RESERVED);
    dec_nxt = '0;
    dec_nxt[0]     = (vd_f != VD_OFF);
    dec_nxt[2:1]   = vd_f;
    dec_nxt[3]     = prot_f;
    dec_nxt[5:4]   = clk_f;
    dec_nxt[8:6]   = rng_f;
    dec_nxt[9]     = (clk_f == CLK_RESONATOR);
    dec_nxt[10]    = dbl_f;
    dec_nxt[12:11] = pkg_f;
    dec_nxt[13]    = wdg_on;
    dec_nxt[14]    = (seq_r == Q_RUN);
    dec_nxt[15]    = (seq_r == Q_HALT) || (seq_r == Q_EXIT);
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pad_r  <= UNBONDED_64;
      warn_r <= '0;
      dec_r  <= 16'h0000;
    end else begin
      pad_r  <= pad_nxt;
      warn_r <= warn_nxt;
      dec_r  <= dec_nxt;
    end
  end

  assign LVD_ENABLE_OUT       = dec_r[0];
  assign AVD_ENABLE_OUT       = dec_r[0];
  assign VD_LEVEL_OUT         = dec_r[2:1];
  assign READOUT_BLOCK_OUT    = dec_r[3];
  assign FLASH_WR_BLOCK_OUT   = dec_r[3];
  assign CLK_SRC_OUT          = dec_r[5:4];
  assign FREQ_RANGE_OUT       = dec_r[8:6];
  assign RES_CURRENT_EN_OUT   = dec_r[9];
  assign PLL_EN_OUT           = dec_r[10];
  assign PKG_SEL_OUT          = dec_r[12:11];
  assign WDG_ENABLE_OUT       = dec_r[13];
  assign CPU_RUN_OUT          = dec_r[14];
  assign HALT_ACTIVE_OUT      = dec_r[15];
  assign SYS_RESET_OUT        = !dec_r[14] && !dec_r[15];
  assign PAD_PULLUP_FORCE_OUT = pad_r;
  assign CFG_WARN_OUT         = warn_r;
endmodule // obc_config_top
`default_nettype wire

// *** sim/obc_prog_tool.sv ***
// programming tool model driving the option byte access pins
`default_nettype none
module obc_prog_tool (
  input  wire logic       clk_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output var logic        mode_out,
  output var logic        sel_out,
  output var logic        wr_out,
  output var logic        rd_out,
  output var logic        erase_out,
  output var logic  [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {mode_out, sel_out, wr_out, rd_out, erase_out} = 5'h00;
    wdata_out = 8'h00;
  end
  // gap between strobes, also covers the input synchronisers
  task automatic gap(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic set_mode(input logic m);
    @(negedge clk_in);
    mode_out = m;
    gap(3);
  endtask
  task automatic wr_byte(input logic s, input logic [7:0] d);
    @(negedge clk_in);
    sel_out = s;
    wdata_out = s ? d : (d | 8'h24);
    wr_out = 1'b1;
    gap(4);
    wr_out = 1'b0;
    gap(3);
    // released data must not look held
    wdata_out = ~wdata_out;
  endtask
  task automatic rd_byte(input logic s, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk_in);
    sel_out = s;
    rd_out = 1'b1;
    // sample off the launching edge; valid stands one cycle only
    for (int n = 0; n < 8 && !ok; n++) begin
      @(negedge clk_in);
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end
    end
    @(negedge clk_in);
    rd_out = 1'b0;
    gap(3);
  endtask
  task automatic er_all();
    @(negedge clk_in);
    erase_out = 1'b1;
    gap(4);
    erase_out = 1'b0;
    gap(3);
  endtask
endmodule // obc_prog_tool
`default_nettype wire

// *** sim/obc_config_top_properties.sv ***
// assertions on the option byte decoder pins
`default_nettype none
module obc_config_top_properties
  import obc_pkg::*;
#(
  parameter int                   N_PORTS     = 6,
  parameter logic [N_PORTS*8-1:0] UNBONDED_64 = '0,
  parameter logic [N_PORTS*8-1:0] UNBONDED_44 = '0
) (
  input wire logic                 CLK_SYS_IN,
  input wire logic                 ARST_N_IN,
  input wire logic                 PROG_MODE_IN,
  input wire logic                 USER_ERASE_DONE_IN,
  input wire logic                 HALT_REQ_IN,
  input wire logic                 WATCHDOG_TYPE_SELECT_ENABLE_IN,
  input wire logic                 PROG_RVALID_OUT,
  input wire logic                 PROG_BUSY_OUT,
  input wire logic                 USER_ERASE_REQ_OUT,
  input wire logic                 CPU_RUN_OUT,
  input wire logic                 SYS_RESET_OUT,
  input wire logic                 HALT_ACTIVE_OUT,
  input wire logic                 WDG_ENABLE_OUT,
  input wire logic                 LVD_ENABLE_OUT,
  input wire logic                 AVD_ENABLE_OUT,
  input wire logic [1:0]           VD_LEVEL_OUT,
  input wire logic [1:0]           PKG_SEL_OUT,
  input wire logic [N_PORTS*8-1:0] PAD_PULLUP_FORCE_OUT,
  input wire logic                 READOUT_BLOCK_OUT,
  input wire logic                 FLASH_WR_BLOCK_OUT,
  input wire logic [1:0]           CLK_SRC_OUT,
  input wire logic [2:0]           FREQ_RANGE_OUT,
  input wire logic                 RES_CURRENT_EN_OUT,
  input wire logic                 PLL_EN_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  AST_HALT_ENTRY: assert property (CPU_RUN_OUT && HALT_REQ_IN |-> ##[1:3]
    (!CPU_RUN_OUT && (HALT_ACTIVE_OUT || SYS_RESET_OUT))) else $error("halt request did not stop the cpu");
  AST_WATCHDOG_TYPE_SELECT: assert property (WATCHDOG_TYPE_SELECT_ENABLE_IN [*3] ##0 CPU_RUN_OUT |-> WDG_ENABLE_OUT)
    else $error("watchdog off while software enabled");
  AST_VD_EN: assert property (CPU_RUN_OUT |-> LVD_ENABLE_OUT == (VD_LEVEL_OUT != 2'h3)
    && AVD_ENABLE_OUT == LVD_ENABLE_OUT) else $error("detector enable disagrees with level");
  AST_PAD_MASK: assert property (CPU_RUN_OUT |-> PAD_PULLUP_FORCE_OUT ==
    ((PKG_SEL_OUT == 2'h0) ? UNBONDED_44 : UNBONDED_64)) else $error("pad pull-up mask wrong");
  AST_PROT_PAIR: assert property (READOUT_BLOCK_OUT == FLASH_WR_BLOCK_OUT)
    else $error("read and write protection differ");
  AST_ERASE_BUSY: assert property (USER_ERASE_REQ_OUT |-> PROG_BUSY_OUT)
    else $error("erase request without busy");
  AST_ERASE_DONE: assert property (USER_ERASE_REQ_OUT && USER_ERASE_DONE_IN |-> ##[1:4] !PROG_BUSY_OUT)
    else $error("busy stuck after user erase");
  AST_RES_CUR: assert property (CPU_RUN_OUT |-> RES_CURRENT_EN_OUT == (CLK_SRC_OUT == 2'h0))
    else $error("resonator current enable wrong");
  AST_REFUSED: assert property ((!PROG_MODE_IN) [*5] |-> !PROG_RVALID_OUT && !$rose(PROG_BUSY_OUT))
    else $error("access taken outside programming mode");
  AST_CFG_HOLD: assert property (CPU_RUN_OUT && $past(CPU_RUN_OUT) |-> $stable({VD_LEVEL_OUT,
    PKG_SEL_OUT, CLK_SRC_OUT, FREQ_RANGE_OUT, PLL_EN_OUT, READOUT_BLOCK_OUT})) else $error("config changed in run");
  AST_RUN_EXCL: assert property (CPU_RUN_OUT |-> !SYS_RESET_OUT && !HALT_ACTIVE_OUT)
    else $error("cpu runs during reset or halt");
  COV_ERASE: cover property (USER_ERASE_REQ_OUT ##[1:3] !PROG_BUSY_OUT [*2]);
  COV_HALT: cover property (HALT_ACTIVE_OUT && !SYS_RESET_OUT);
  COV_PLL: cover property (CPU_RUN_OUT && PLL_EN_OUT);
endmodule // obc_config_top_properties
bind obc_config_top obc_config_top_properties #(.N_PORTS(N_PORTS), .UNBONDED_64(UNBONDED_64),
  .UNBONDED_44(UNBONDED_44)) obc_config_top_properties_inst (.CLK_SYS_IN, .ARST_N_IN, .PROG_MODE_IN,
  .USER_ERASE_DONE_IN, .HALT_REQ_IN, .WATCHDOG_TYPE_SELECT_ENABLE_IN, .PROG_RVALID_OUT, .PROG_BUSY_OUT, .USER_ERASE_REQ_OUT,
  .CPU_RUN_OUT, .SYS_RESET_OUT, .HALT_ACTIVE_OUT, .WDG_ENABLE_OUT, .LVD_ENABLE_OUT, .AVD_ENABLE_OUT,
  .VD_LEVEL_OUT, .PKG_SEL_OUT, .PAD_PULLUP_FORCE_OUT, .READOUT_BLOCK_OUT, .FLASH_WR_BLOCK_OUT, .CLK_SRC_OUT,
  .FREQ_RANGE_OUT, .RES_CURRENT_EN_OUT, .PLL_EN_OUT);
`default_nettype wire

// *** sim/obc_config_top_tb.sv ***
// self-checking bench for the option byte decoder
`default_nettype none
module obc_config_top_tb;
  import obc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // setup: shortened counts keep the run brief
  // ----------------------------------------------------------------
  localparam int LONG_N = 20;
  localparam int SHORT_N = 8;
  localparam logic [47:0] UNB_64 = 48'h0000_0000_00C3;
  localparam logic [47:0] UNB_44 = 48'hFF00_0000_F000;
  localparam logic [7:0] CFG0 [4] = '{8'hA5, 8'hEF, 8'hBE, 8'hF5};
  localparam logic [7:0] CFG1 [4] = '{8'h01, 8'hD2, 8'hE5, 8'hB7};
  logic        clk, arst_n, halt_req, wake, sw_en, er_done, mode, sel, wr, rd, er;
  logic        rvalid, busy, ereq, run, srst, halt_act, wdg_en, lvd_en, avd_en, ro_blk, fw_blk, res_cur, pll_en;
  logic [1:0]  vd, pkg, clk_src;
  logic [2:0]  freq;
  logic [3:0]  warn;
  logic [7:0]  wdata, rdata;
  logic [47:0] pads;
  int          mismatches = 0;
  int          n_tests = 0;
  always #50 clk = ~clk;
  obc_config_top #(.UNBONDED_64(UNB_64), .UNBONDED_44(UNB_44),
    .LONG_CYCLES(13'h0014), .SHORT_CYCLES(13'h0008)) obc_config_top_inst (
    .CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .PROG_MODE_IN(mode), .PROG_SEL_IN(sel), .PROG_WR_IN(wr),
    .PROG_RD_IN(rd), .PROG_ERASE_IN(er), .PROG_WDATA_IN(wdata), .USER_ERASE_DONE_IN(er_done),
    .HALT_REQ_IN(halt_req), .HALT_WAKE_IN(wake), .WATCHDOG_TYPE_SELECT_ENABLE_IN(sw_en), .PROG_RDATA_OUT(rdata),
    .PROG_RVALID_OUT(rvalid), .PROG_BUSY_OUT(busy), .USER_ERASE_REQ_OUT(ereq), .CPU_RUN_OUT(run),
    .SYS_RESET_OUT(srst), .HALT_ACTIVE_OUT(halt_act), .WDG_ENABLE_OUT(wdg_en), .LVD_ENABLE_OUT(lvd_en),
    .AVD_ENABLE_OUT(avd_en), .VD_LEVEL_OUT(vd), .PKG_SEL_OUT(pkg), .PAD_PULLUP_FORCE_OUT(pads),
    .READOUT_BLOCK_OUT(ro_blk), .FLASH_WR_BLOCK_OUT(fw_blk), .CLK_SRC_OUT(clk_src), .FREQ_RANGE_OUT(freq),
    .RES_CURRENT_EN_OUT(res_cur), .PLL_EN_OUT(pll_en), .CFG_WARN_OUT(warn));
  obc_prog_tool obc_prog_tool_inst (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .mode_out(mode),
    .sel_out(sel), .wr_out(wr), .rd_out(rd), .erase_out(er), .wdata_out(wdata));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_run(inout int n);
    while (run !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 90) begin
        chk("cpu run", 1'b1, run);
        print_verdict();
      end
    end
  endtask
  task automatic chk_rd(input logic s, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    obc_prog_tool_inst.rd_byte(s, d, ok);
    chk("read valid", 1'b1, ok);
    chk("read data", exp, d);
  endtask
  // halt with watchdog active and reset-on-halt set reruns the reset phase
  task automatic relatch(output int n);
    n = 4;
    halt_req = 1'b1;
    cyc(1);
    halt_req = 1'b0;
    cyc(3);
    wait_run(n);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_blank();
    int n = 0;
    wait_run(n);
    chk("boot len", 1'b1, n >= SHORT_N && n <= SHORT_N + 4);
    chk("clk src", 2'h2, clk_src);
    chk("pads", UNB_64, pads);
    chk("warn", 4'h0, warn);
    obc_prog_tool_inst.set_mode(1'b1);
    chk_rd(1'b0, OPT0_BLANK);
    chk_rd(1'b1, OPT1_BLANK);
  endtask
  task automatic t_decode();
    int n;
    int nn;
    logic [7:0] a;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      a = CFG0[i];
      b = CFG1[i];
      nn = b[6] ? SHORT_N : LONG_N;
      obc_prog_tool_inst.wr_byte(1'b0, a);
      obc_prog_tool_inst.wr_byte(1'b1, b);
      chk_rd(1'b0, a);
      chk_rd(1'b1, b);
      relatch(n);
      chk("reset len", 1'b1, n >= nn && n <= nn + 8);
      sw_en = 1'b0;
      cyc(2);
      chk("wdg", !a[6], wdg_en);
      sw_en = 1'b1;
      chk("vd", a[4:3], vd);
      chk("lvd", a[4:3] != 2'h3, lvd_en);
      chk("avd", a[4:3] != 2'h3, avd_en);
      chk("pkg", {b[7], a[1]}, pkg);
      chk("pads", ({b[7], a[1]} == 2'h0) ? UNB_44 : UNB_64, pads);
      chk("ro blk", !a[0], ro_blk);
      chk("fw blk", !a[0], fw_blk);
      chk("clk src", b[5:4], clk_src);
      chk("range", b[3:1], freq);
      chk("res cur", b[5:4] == 2'h0, res_cur);
      chk("pll", !b[0], pll_en);
      chk("warn", {b[5:4] == 2'h1, 3'h0}, warn);
    end
  endtask
  task automatic t_halt();
    int n = 0;
    obc_prog_tool_inst.wr_byte(1'b0, 8'h65);
    relatch(n);
    halt_req = 1'b1;
    cyc(1);
    halt_req = 1'b0;
    cyc(12);
    chk("halted", 3'h4, {halt_act, srst, run});
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    n = 1;
    wait_run(n);
    chk("exit len", 1'b1, n >= LONG_N && n <= LONG_N + 4);
  endtask
  task automatic t_erase();
    logic [7:0] d;
    logic ok;
    obc_prog_tool_inst.set_mode(1'b0);
    obc_prog_tool_inst.wr_byte(1'b1, 8'h00);
    obc_prog_tool_inst.rd_byte(1'b1, d, ok);
    chk("refused rd", 1'b0, ok);
    obc_prog_tool_inst.set_mode(1'b1);
    chk_rd(1'b1, 8'hB7);
    obc_prog_tool_inst.wr_byte(1'b0, 8'hA4);
    obc_prog_tool_inst.er_all();
    chk("wait user erase", 2'h3, {ereq, busy});
    er_done = 1'b1;
    cyc(1);
    er_done = 1'b0;
    cyc(4);
    chk("erase end", 2'h0, {ereq, busy});
    chk_rd(1'b0, OPT_ERASED);
    chk_rd(1'b1, OPT_ERASED);
    obc_prog_tool_inst.er_all();
    chk("plain erase", 2'h0, {ereq, busy});
    chk("latched src", 2'h3, clk_src);
  endtask
  initial begin
    {clk, arst_n, halt_req, wake, er_done} = 5'h00;
    sw_en = 1'b1;
    cyc(10);
    arst_n = 1'b1;
    t_blank();
    t_decode();
    t_halt();
    t_erase();
    print_verdict();
  end
endmodule // obc_config_top_tb
`default_nettype wire
